// file: mrw_defs.svh
// constants for the multi-register write query decoder
`ifndef MRW_DEFS_SVH
`define MRW_DEFS_SVH
`define MRW_FUNC_CODE   8'h10
`define MRW_MAX_REGS    16'h0010
`define MRW_ZERO_COUNT  16'h0000
`define MRW_ONE         16'h0001
`endif

// file: mrw_pkg.sv
// types for the multi-register write query decoder
package mrw_pkg;
  typedef enum logic [2:0] {
    ST_FUNC  = 3'b000,
    ST_ADDR  = 3'b001,
    ST_COUNT = 3'b010,
    ST_BYTES = 3'b011,
    ST_DATA  = 3'b100,
    ST_SKIP  = 3'b101
  } state_t;
  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] data;
  } reg_write_t;
  typedef struct packed {
    logic [15:0] start;
    logic [15:0] count;
  } reply_t;
endpackage : mrw_pkg

// file: mrw_decoder.sv
// byte-serial decoder for the multi-register write query
`timescale 1ns/1ps
`default_nettype none
`include "mrw_defs.svh"
module mrw_decoder (
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic              ce,
  input  wire logic              frame_start,
  input  wire logic              byte_valid,
  input  wire logic [7:0]        byte_data,
  output var  logic              wr_valid,
  output var  mrw_pkg::reg_write_t wr,
  output var  logic              done,
  output var  mrw_pkg::reply_t   reply,
  output var  logic              malformed,
  output var  logic              other_func
);
  mrw_pkg::state_t state_q;
  logic            hi_q;
  logic [7:0]      upper_q;
  logic [15:0]     start_q;
  logic [15:0]     count_q;
  logic [15:0]     left_q;
  logic [15:0]     addr_q;
  logic            wr_valid_q, done_q, malformed_q, other_q;
  mrw_pkg::reg_write_t wr_q;

  wire        take     = ce && byte_valid;
  wire [15:0] word     = {upper_q, byte_data};
  wire        over_max = word > `MRW_MAX_REGS;
  wire        zero_cnt = word == `MRW_ZERO_COUNT;
  // twice the count, compared in 9 bits so 16 regs = 32 bytes fits
  wire        bytes_ok = {1'b0, byte_data} == {count_q[7:0], 1'b0};
  wire        last_reg = left_q == `MRW_ONE;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q     <= mrw_pkg::ST_FUNC;
      hi_q        <= 1'b1;
      upper_q     <= 8'h00;
      start_q     <= 16'h0000;
      count_q     <= 16'h0000;
      left_q      <= 16'h0000;
      addr_q      <= 16'h0000;
      wr_valid_q  <= 1'b0;
      wr_q        <= '0;
      done_q      <= 1'b0;
      malformed_q <= 1'b0;
      other_q     <= 1'b0;
    end else if (ce) begin
      wr_valid_q  <= 1'b0;
      done_q      <= 1'b0;
      malformed_q <= 1'b0;
      other_q     <= 1'b0;
      if (frame_start) begin
        state_q <= mrw_pkg::ST_FUNC;
        hi_q    <= 1'b1;
      end else if (take) begin
        case (state_q)
          mrw_pkg::ST_FUNC: begin
            if (byte_data == `MRW_FUNC_CODE) begin
              state_q <= mrw_pkg::ST_ADDR;
            end else begin
              other_q <= 1'b1;
              state_q <= mrw_pkg::ST_SKIP;
            end
            hi_q <= 1'b1;
          end
          mrw_pkg::ST_ADDR: begin
            if (hi_q) begin
              upper_q <= byte_data;
            end else begin
              start_q <= word;
              addr_q  <= word;
              state_q <= mrw_pkg::ST_COUNT;
            end
            hi_q <= !hi_q;
          end
          mrw_pkg::ST_COUNT: begin
            if (hi_q) begin
              upper_q <= byte_data;
            end else if (over_max || zero_cnt) begin
              malformed_q <= 1'b1;
              state_q     <= mrw_pkg::ST_SKIP;
            end else begin
              count_q <= word;
              left_q  <= word;
              state_q <= mrw_pkg::ST_BYTES;
            end
            hi_q <= !hi_q;
          end
          mrw_pkg::ST_BYTES: begin
            if (bytes_ok) begin
              state_q <= mrw_pkg::ST_DATA;
            end else begin
              malformed_q <= 1'b1;
              state_q     <= mrw_pkg::ST_SKIP;
            end
            hi_q <= 1'b1;
          end
          mrw_pkg::ST_DATA: begin
            if (hi_q) begin
              upper_q <= byte_data;
            end else begin
              wr_valid_q <= 1'b1;
              wr_q       <= '{addr: addr_q, data: word};
              addr_q     <= addr_q + `MRW_ONE;
              left_q     <= left_q - `MRW_ONE;
              if (last_reg) begin
                done_q  <= 1'b1;
                state_q <= mrw_pkg::ST_SKIP;
              end
            end
            hi_q <= !hi_q;
          end
          mrw_pkg::ST_SKIP: begin
            state_q <= mrw_pkg::ST_SKIP;
          end
          default: begin
            state_q <= mrw_pkg::ST_FUNC;
          end
        endcase
      end
    end
  end

  assign wr_valid   = wr_valid_q;
  assign wr         = wr_q;
  assign done       = done_q;
  assign reply      = '{start: start_q, count: count_q};
  assign malformed  = malformed_q;
  assign other_func = other_q;

  // checker helper: last address committed in this frame, cleared per frame
  logic        chk_seen_q;
  logic [15:0] chk_prev_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      chk_seen_q <= 1'b0;
      chk_prev_q <= 16'h0000;
    end else if (ce) begin
      if (frame_start) begin
        chk_seen_q <= 1'b0;
      end else if (wr_valid) begin
        chk_seen_q <= 1'b1;
        chk_prev_q <= wr.addr;
      end
    end
  end

  property p_func_route;
    @(posedge clk) disable iff (!rstn)
      (ce && take && !frame_start && state_q == mrw_pkg::ST_FUNC && byte_data != `MRW_FUNC_CODE)
        |=> other_func;
  endproperty
  a_func_route: assert property (p_func_route) else $error("non 10h function not flagged");

  property p_addr_load;
    @(posedge clk) disable iff (!rstn)
      (ce && take && !frame_start && state_q == mrw_pkg::ST_ADDR && !hi_q)
        |=> reply.start == {$past(upper_q), $past(byte_data)};
  endproperty
  a_addr_load: assert property (p_addr_load) else $error("start address misassembled");

  property p_count_load;
    @(posedge clk) disable iff (!rstn)
      (ce && take && !frame_start && state_q == mrw_pkg::ST_COUNT && !hi_q && !over_max && !zero_cnt)
        |=> reply.count == {$past(upper_q), $past(byte_data)};
  endproperty
  a_count_load: assert property (p_count_load) else $error("count misassembled");

  property p_bytes_check;
    @(posedge clk) disable iff (!rstn)
      (ce && take && !frame_start && state_q == mrw_pkg::ST_BYTES && !bytes_ok) |=> malformed;
  endproperty
  a_bytes_check: assert property (p_bytes_check) else $error("byte count mismatch missed");

  // a frozen pulse under ce low is not rechecked against later bytes
  property p_data_word;
    @(posedge clk) disable iff (!rstn)
      (wr_valid && $past(ce)) |-> wr.data == {$past(upper_q), $past(byte_data)};
  endproperty
  a_data_word: assert property (p_data_word) else $error("data word misassembled");

  property p_max_regs;
    @(posedge clk) disable iff (!rstn)
      (ce && take && !frame_start && state_q == mrw_pkg::ST_COUNT && !hi_q && over_max)
        |=> malformed ##1 (state_q == mrw_pkg::ST_SKIP);
  endproperty
  a_max_regs: assert property (p_max_regs) else $error("count over 16 accepted");

  property p_ascending;
    @(posedge clk) disable iff (!rstn)
      (wr_valid && chk_seen_q) |-> wr.addr == chk_prev_q + `MRW_ONE;
  endproperty
  a_ascending: assert property (p_ascending) else $error("writes not ascending");

  property p_refuse;
    @(posedge clk) disable iff (!rstn)
      (take && !frame_start && state_q == mrw_pkg::ST_SKIP)
        |=> !(wr_valid || done || malformed || other_func);
  endproperty
  a_refuse: assert property (p_refuse) else $error("byte acted on after end of query");

  property p_done_last;
    @(posedge clk) disable iff (!rstn)
      done |-> wr_valid && wr.addr == reply.start + reply.count - `MRW_ONE;
  endproperty
  a_done_last: assert property (p_done_last) else $error("done not on last register");

  c_write:     cover property (@(posedge clk) disable iff (!rstn) wr_valid);
  c_done:      cover property (@(posedge clk) disable iff (!rstn) done);
  c_malformed: cover property (@(posedge clk) disable iff (!rstn) malformed);
  c_other:     cover property (@(posedge clk) disable iff (!rstn) other_func);
  c_burst:     cover property (@(posedge clk) disable iff (!rstn) wr_valid && chk_seen_q);
endmodule : mrw_decoder
`default_nettype wire

// file: mrw_master.sv
// query source standing in for the bus master
`timescale 1ns/1ps
`default_nettype none
module mrw_master (
  input  wire logic       clk,
  output var  logic       frame_start,
  output var  logic       byte_valid,
  output var  logic [7:0] byte_data
);
  initial begin
    frame_start = 1'b0;
    byte_valid  = 1'b0;
    byte_data   = 8'h00;
  end
  task automatic send(input logic [7:0] fc, input logic [15:0] start, input logic [15:0] cnt,
                      input logic [7:0] bc, input int cut);
    logic [7:0]  q[$];
    logic [15:0] v;
    q = {fc, start[15:8], start[7:0], cnt[15:8], cnt[7:0], bc};
    for (int i = 0; i < 17 && i < cnt; i++) begin
      v = 16'hA050 + 16'h0101 * i[15:0];
      q.push_back(v[15:8]);
      q.push_back(v[7:0]);
    end
    @(posedge clk);
    frame_start <= 1'b1;
    @(posedge clk);
    frame_start <= 1'b0;
    foreach (q[i]) begin
      if (cut == 0 || i < cut) begin
        @(posedge clk);
        byte_valid <= 1'b1;
        byte_data  <= q[i];
      end
    end
    // idle line shows junk, not the last byte
    @(posedge clk);
    byte_valid <= 1'b0;
    byte_data  <= ~byte_data;
  endtask : send
endmodule : mrw_master
`default_nettype wire

// file: mrw_decoder_test.sv
// self-checking bench for the query decoder
`timescale 1ns/1ps
`default_nettype none
module mrw_decoder_test;
  typedef struct packed {
    logic [7:0]  fc;
    logic [15:0] cnt;
    logic [7:0]  bc;
    logic [7:0]  ewr;
    logic [2:0]  ev;
  } row_t;
  logic                clk;
  logic                rstn;
  logic                ce;
  wire logic           fs;
  wire logic           bv;
  wire logic [7:0]     bd;
  logic                wr_valid;
  mrw_pkg::reg_write_t wr;
  logic                done;
  mrw_pkg::reply_t     reply;
  logic                malformed;
  logic                other_func;
  logic [15:0]         start;
  int                  n_fail = 0;
  int                  samples_checked = 0;
  int                  n_wr, n_done, n_bad, n_oth;
  row_t                rows[6] = '{
    '{8'h10, 16'h0001, 8'h02, 8'h01, 3'b100},
    '{8'h10, 16'h0010, 8'h20, 8'h10, 3'b100},
    '{8'h10, 16'h0000, 8'h00, 8'h00, 3'b010},
    '{8'h10, 16'h0011, 8'h22, 8'h00, 3'b010},
    '{8'h10, 16'h0003, 8'h07, 8'h00, 3'b010},
    '{8'h03, 16'h0002, 8'h04, 8'h00, 3'b001}};
  mrw_master i_master (.clk(clk), .frame_start(fs), .byte_valid(bv), .byte_data(bd));
  mrw_decoder i_dut (.clk(clk), .rstn(rstn), .ce(ce), .frame_start(fs), .byte_valid(bv),
    .byte_data(bd), .wr_valid(wr_valid), .wr(wr), .done(done), .reply(reply),
    .malformed(malformed), .other_func(other_func));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask : cmp
  task automatic summarize;
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : summarize
  // sampled mid-cycle, away from the launching edge
  always @(negedge clk) begin
    if (rstn && wr_valid === 1'b1) begin
      cmp("wr", {start + n_wr[15:0], 16'hA050 + 16'h0101 * n_wr[15:0]}, wr);
      n_wr++;
    end
    n_done += int'(done === 1'b1);
    n_bad  += int'(malformed === 1'b1);
    n_oth  += int'(other_func === 1'b1);
  end
  task automatic check(input row_t r, input int cut);
    n_wr = 0; n_done = 0; n_bad = 0; n_oth = 0;
    i_master.send(r.fc, start, r.cnt, r.bc, cut);
    repeat (3) @(posedge clk);
    cmp("writes", 32'(r.ewr), n_wr);
    cmp("done/bad/other", 32'(r.ev), {n_done[0], n_bad[0], n_oth[0]});
    cmp("pulses", 32'(r.ev != 3'b000), n_done + n_bad + n_oth);
    if (r.ev[2]) cmp("reply", {start, r.cnt}, reply);
  endtask : check
  initial begin
    rstn = 1'b0;
    ce = 1'b1;
    start = 16'h0604;
    repeat (6) @(posedge clk);
    cmp("reset outs", 32'h0000_0000, {wr_valid, done, malformed, other_func});
    cmp("reset wr", 32'h0000_0000, wr);
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    // rows: 1 and 16 registers, count 0 and 17, bad byte count, other function
    foreach (rows[i]) begin
      start = 16'h0604 + 16'h0104 * i[15:0];
      check(rows[i], 0);
    end
    // clock enable low: nothing is taken
    @(posedge clk);
    ce <= 1'b0;
    check('{8'h10, 16'h0001, 8'h02, 8'h00, 3'b000}, 0);
    @(posedge clk);
    ce <= 1'b1;
    // abandoned frame, then a full one restarted by frame_start
    start = 16'hFFFE;
    i_master.send(8'h10, start, 16'h0002, 8'h04, 7);
    check('{8'h10, 16'h0002, 8'h04, 8'h02, 3'b100}, 0);
    // reset in mid-query: the register already committed stays counted
    start = 16'h0100;
    n_wr = 0;
    i_master.send(8'h10, start, 16'h0002, 8'h04, 8);
    @(posedge clk);
    cmp("cut writes", 32'h0000_0001, n_wr);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    cmp("reset reply", 32'h0000_0000, reply);
    cmp("reset pulses", 32'h0000_0000, {wr_valid, done, malformed, other_func});
    rstn <= 1'b1;
    check(rows[0], 0);
    summarize();
  end
endmodule : mrw_decoder_test
`default_nettype wire
